// [src/seq_stop_ctrl.sv]
// sequencer stop and restart control: state machine, soft reset, status flags, irq
`timescale 1ns/10ps

// Summary of operation
// R01 - stop instruction: run to stop for exactly one cycle, then start; code holds stop until fetch-active is low
// R02 - soft reset pulses one cycle on stop-to-start, after all fetches finish
// R03 - stop request bit goes via stop; async halt request via async halt state
// R04 - interrupt raised when the stop-seen flag becomes set
// R05 - stop-seen set after passing stop state; separate flag for async halt
// R06 - stop-seen flag clears when software writes one to it
// R07 - fetch-active reads zero only when all instruction fetches completed
// R08 - fetch groups of sixteen 128-bit instructions; up to fifteen follow a stop; code fetches a whole next group of sixteen after a stop in the last slot
// R09 - each group fetched as two incr16 bursts of 64-bit beats
// R10 - sample dma pre-empts fetch between bursts only during acquisition
// R11 - status accesses always acknowledged, even in the soft-reset cycle
// R12 - software should use the interrupt, not polling, on completion
// R13 - polling software checks stop-seen, clears it, checks fetch-active idle
// R14 - every work-register access is acknowledged, held over the soft reset
module seq_stop_ctrl (
  // clock and reset
  input  wire logic                 crossbar_clock_i,
  input  wire logic                 reset_n_i,
  // software control and status
  input  seq_stop_pkg::seq_ctrl_t   ctrl_i,
  output seq_stop_pkg::seq_status_t status_o,
  output logic                      irq_o,
  // status register access
  input  wire logic                 status_req_i,
  output logic                      status_ack_o,
  // work register access
  input  seq_stop_pkg::work_req_t   work_req_i,
  output logic                      work_ack_o,
  output logic [31:0]               work_rdata_o,
  // crossbar fetch port
  output logic                      burst_req_o,
  input  wire logic                 burst_grant_i,
  input  wire logic                 beat_valid_i,
  input  wire logic [63:0]          beat_data_i,
  input  wire logic                 sample_dma_req_i,
  input  wire logic                 acq_active_i,
  // engine view
  output logic                      soft_reset_o,
  output logic                      instr_valid_o,
  output logic [127:0]              instr_o
);
  import seq_stop_pkg::*;

  // ****************************************************************
  // fetch engine
  // ****************************************************************
  logic        dma_busy;
  logic        beat_take;
  logic [63:0] beat_data;
  logic        fetch_start;

  cmd_fetch_dma u_fetch (
    .crossbar_clock_i        (crossbar_clock_i),
    .reset_n_i        (reset_n_i),
    .fetch_start_i    (fetch_start),
    .acq_active_i     (acq_active_i),
    .burst_req_o      (burst_req_o),
    .burst_grant_i    (burst_grant_i),
    .beat_valid_i     (beat_valid_i),
    .beat_data_i      (beat_data_i),
    .sample_dma_req_i (sample_dma_req_i),
    .busy_o           (dma_busy),
    .beat_take_o      (beat_take),
    .beat_data_o      (beat_data)
  );

  // ****************************************************************
  // instruction assembly: two beats make one instruction
  // ****************************************************************
  logic                  half_reg, half_next;
  logic [63:0]           low_reg, low_next;
  logic                  ivalid_reg, ivalid_next;
  logic [127:0]          instr_reg, instr_next;
  logic [SLOT_CNT_W-1:0] slot_reg, slot_next;

  always_comb begin
    half_next   = half_reg;
    low_next    = low_reg;
    ivalid_next = 1'b0;
    instr_next  = instr_reg;
    slot_next   = slot_reg;
    if (beat_take) begin
      half_next = ~half_reg;
      if (!half_reg) begin
        low_next = beat_data;
      end else begin
        ivalid_next = 1'b1;
        instr_next  = {beat_data, low_reg};
        slot_next   = (slot_reg == SLOT_LAST) ? SLOT_ZERO : slot_reg + 1'b1; // [R08]
      end
    end
  end

  always_ff @(posedge crossbar_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      half_reg   <= 1'b0;
      low_reg    <= 64'h0000_0000_0000_0000;
      ivalid_reg <= 1'b0;
      instr_reg  <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      slot_reg   <= SLOT_ZERO;
    end else begin
      half_reg   <= half_next;
      low_reg    <= low_next;
      ivalid_reg <= ivalid_next;
      instr_reg  <= instr_next;
      slot_reg   <= slot_next;
    end
  end

  assign instr_valid_o = ivalid_reg;
  assign instr_o       = instr_reg;

  // ****************************************************************
  // sequencer state machine
  // ****************************************************************
  seq_state_t state_reg, state_next;
  logic       stop_instr;
  logic       skip_reg, skip_next;
  logic       soft_rst_reg, soft_rst_next;

  function automatic logic is_stop(input logic [127:0] ins);
    return ins[OPC_MSB:OPC_LSB] == OPC_STOP;
  endfunction

  // stop opcodes in instructions already fetched behind a stop are ignored
  assign stop_instr  = ivalid_reg & is_stop(instr_reg) & ~skip_reg; // [R08]
  assign fetch_start = (state_reg == ST_RUN) & ~dma_busy & ~skip_reg;

  always_comb begin
    state_next    = state_reg;
    soft_rst_next = 1'b0;
    skip_next     = skip_reg;
    unique case (state_reg)
      ST_START: begin
        skip_next = 1'b0;
        if (ctrl_i.go) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ctrl_i.async_halt_req) begin
          state_next = ST_ASYNC_HALT; // [R03]
          skip_next  = 1'b1;
        end else if (stop_instr || ctrl_i.stop_req) begin
          state_next = ST_STOP; // [R01] [R03]
          skip_next  = 1'b1;
        end
      end
      ST_STOP, ST_ASYNC_HALT: begin
        // leave after one cycle unless fetches remain; soft reset marks the exit
        if (!dma_busy) begin
          state_next    = ST_START; // [R01]
          soft_rst_next = 1'b1; // [R02]
        end
      end
      default: begin
        state_next = ST_START;
      end
    endcase
  end

  always_ff @(posedge crossbar_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg    <= ST_START;
      soft_rst_reg <= 1'b0;
      skip_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      soft_rst_reg <= soft_rst_next;
      skip_reg     <= skip_next;
    end
  end

  assign soft_reset_o = soft_rst_reg;

  // ****************************************************************
  // status flags and interrupt
  // ****************************************************************
  logic stop_seen_reg, stop_seen_next;
  logic ahalt_seen_reg, ahalt_seen_next;
  logic irq_reg, irq_next;

  always_comb begin
    stop_seen_next  = stop_seen_reg;
    ahalt_seen_next = ahalt_seen_reg;
    // set wins over a clear in the same cycle
    if (ctrl_i.stop_seen_w1c) begin
      stop_seen_next = FLAG_CLEAR; // [R06]
    end
    if (state_reg == ST_STOP) begin
      stop_seen_next = FLAG_SET; // [R05]
    end
    if (ctrl_i.async_halt_seen_w1c) begin
      ahalt_seen_next = FLAG_CLEAR;
    end
    if (state_reg == ST_ASYNC_HALT) begin
      ahalt_seen_next = FLAG_SET; // [R05]
    end
    irq_next = stop_seen_next & ~stop_seen_reg; // [R04]
  end

  always_ff @(posedge crossbar_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_seen_reg  <= FLAG_CLEAR;
      ahalt_seen_reg <= FLAG_CLEAR;
      irq_reg        <= 1'b0;
    end else begin
      stop_seen_reg  <= stop_seen_next;
      ahalt_seen_reg <= ahalt_seen_next;
      irq_reg        <= irq_next;
    end
  end

  assign irq_o                         = irq_reg;
  assign status_o.stop_seen_flag       = stop_seen_reg;
  assign status_o.async_halt_seen_flag = ahalt_seen_reg;
  assign status_o.fetch_active         = dma_busy; // [R07]
  assign status_o.state                = state_reg;

  // ****************************************************************
  // bus access
  // ****************************************************************
  // status reads never wait, soft reset or not
  assign status_ack_o = status_req_i; // [R11]

  work_reg_guard u_guard (
    .crossbar_clock_i    (crossbar_clock_i),
    .reset_n_i    (reset_n_i),
    .req_i        (work_req_i),
    .ack_o        (work_ack_o),
    .rdata_o      (work_rdata_o),
    .soft_reset_i (soft_rst_reg)
  );

endmodule

// [src/seq_stop_pkg.sv]
// package: states, constants and carrier structs of the sequencer stop control
package seq_stop_pkg;

  // instruction groups and fetch bursts
  localparam int unsigned INSTR_BITS      = 128;
  localparam int unsigned GROUP_INSTRS    = 16;
  localparam int unsigned BEAT_BITS       = 64;
  localparam int unsigned BURST_BEATS     = 16;
  localparam int unsigned BURSTS_PER_GRP  = (INSTR_BITS * GROUP_INSTRS) / (BEAT_BITS * BURST_BEATS);
  localparam int unsigned BEAT_CNT_W      = $clog2(BURST_BEATS);
  localparam int unsigned BURST_CNT_W     = 1;
  localparam int unsigned SLOT_CNT_W      = $clog2(GROUP_INSTRS);
  localparam logic [BEAT_CNT_W-1:0]  BEAT_LAST  = BEAT_CNT_W'(BURST_BEATS - 1);
  localparam logic [BURST_CNT_W-1:0] BURST_LAST = BURST_CNT_W'(BURSTS_PER_GRP - 1);
  localparam logic [SLOT_CNT_W-1:0]  SLOT_LAST  = SLOT_CNT_W'(GROUP_INSTRS - 1);
  localparam logic [SLOT_CNT_W-1:0]  SLOT_ZERO  = 4'h0;
  localparam logic [BEAT_CNT_W-1:0]  BEAT_ZERO  = 4'h0;
  localparam logic [BURST_CNT_W-1:0] BURST_ZERO = 1'h0;

  // instruction opcode field holding the stop command
  localparam int unsigned OPC_MSB  = 127;
  localparam int unsigned OPC_LSB  = 120;
  localparam logic [7:0]  OPC_STOP = 8'h00;

  localparam logic FLAG_SET   = 1'b1;
  localparam logic FLAG_CLEAR = 1'b0;

  typedef enum logic [2:0] {
    ST_START,
    ST_RUN,
    ST_STOP,
    ST_ASYNC_HALT
  } seq_state_t;

  // software control strobes
  typedef struct packed {
    logic go;
    logic stop_req;
    logic async_halt_req;
    logic stop_seen_w1c;
    logic async_halt_seen_w1c;
  } seq_ctrl_t;

  // status seen by software
  typedef struct packed {
    logic       stop_seen_flag;
    logic       async_halt_seen_flag;
    logic       fetch_active;
    seq_state_t state;
  } seq_status_t;

  // work-register bus request from the peripheral bridge
  typedef struct packed {
    logic        req;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } work_req_t;

endpackage

// [src/cmd_fetch_dma.sv]
// command-fetch dma: one group of 16 instructions as two incr16 bursts of 64-bit beats
`timescale 1ns/10ps
module cmd_fetch_dma (
  // clock and reset
  input  wire logic        crossbar_clock_i,
  input  wire logic        reset_n_i,
  // control
  input  wire logic        fetch_start_i,
  input  wire logic        acq_active_i,
  // crossbar side
  output logic             burst_req_o,
  input  wire logic        burst_grant_i,
  input  wire logic        beat_valid_i,
  input  wire logic [63:0] beat_data_i,
  input  wire logic        sample_dma_req_i,
  // status
  output logic             busy_o,
  output logic             beat_take_o,
  output logic [63:0]      beat_data_o
);
  import seq_stop_pkg::*;

  logic                   busy_reg, busy_next;
  logic                   inburst_reg, inburst_next;
  logic [BEAT_CNT_W-1:0]  beat_reg, beat_next;
  logic [BURST_CNT_W-1:0] burst_reg, burst_next;
  logic [63:0]            data_reg, data_next;
  logic                   take_reg, take_next;
  logic                   yield;

  // sample dma may take the crossbar only between bursts, and only during acquisition
  assign yield = acq_active_i & sample_dma_req_i; // [R10]
  assign burst_req_o = busy_reg & ~inburst_reg & ~yield;

  always_comb begin
    busy_next    = busy_reg;
    inburst_next = inburst_reg;
    beat_next    = beat_reg;
    burst_next   = burst_reg;
    data_next    = data_reg;
    take_next    = 1'b0;
    if (!busy_reg) begin
      if (fetch_start_i) begin
        busy_next  = 1'b1; // [R08]
        burst_next = BURST_ZERO;
        beat_next  = BEAT_ZERO;
      end
    end else if (!inburst_reg) begin
      if (burst_req_o && burst_grant_i) begin
        inburst_next = 1'b1;
      end
    end else if (beat_valid_i) begin
      take_next = 1'b1;
      data_next = beat_data_i;
      beat_next = beat_reg + 1'b1;
      if (beat_reg == BEAT_LAST) begin
        inburst_next = 1'b0; // [R09]
        beat_next    = BEAT_ZERO;
        burst_next   = burst_reg + 1'b1;
        if (burst_reg == BURST_LAST) begin
          busy_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge crossbar_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_reg    <= 1'b0;
      inburst_reg <= 1'b0;
      beat_reg    <= BEAT_ZERO;
      burst_reg   <= BURST_ZERO;
      data_reg    <= 64'h0000_0000_0000_0000;
      take_reg    <= 1'b0;
    end else begin
      busy_reg    <= busy_next;
      inburst_reg <= inburst_next;
      beat_reg    <= beat_next;
      burst_reg   <= burst_next;
      data_reg    <= data_next;
      take_reg    <= take_next;
    end
  end

  assign busy_o      = busy_reg;
  assign beat_take_o = take_reg;
  assign beat_data_o = data_reg;

endmodule

// [src/work_reg_guard.sv]
// work-register access guard: holds an access across the soft-reset pulse, then acknowledges
`timescale 1ns/10ps
module work_reg_guard (
  // clock and reset
  input  wire logic           crossbar_clock_i,
  input  wire logic           reset_n_i,
  // peripheral bus
  input  seq_stop_pkg::work_req_t req_i,
  output logic                ack_o,
  output logic [31:0]         rdata_o,
  // soft reset
  input  wire logic           soft_reset_i
);
  import seq_stop_pkg::*;

  localparam int unsigned NREG = 4;

  logic [31:0] regs_reg [NREG];
  logic [31:0] regs_next [NREG];
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  idx;

  assign idx = req_i.addr[3:2];

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      regs_next[i] = soft_reset_i ? 32'h0000_0000 : regs_reg[i];
    end
    ack_next   = 1'b0;
    rdata_next = rdata_reg;
    // an access meeting the soft-reset cycle waits one cycle instead of being lost
    if (req_i.req && !ack_reg && !soft_reset_i) begin // [R14]
      ack_next = 1'b1;
      if (req_i.write) begin
        regs_next[idx] = req_i.wdata;
      end else begin
        rdata_next = regs_reg[idx];
      end
    end
  end

  always_ff @(posedge crossbar_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_reg[i] <= 32'h0000_0000;
      end
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      regs_reg  <= regs_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ack_o   = ack_reg;
  assign rdata_o = rdata_reg;

endmodule

// [tb/seq_stop_ctrl_chk.sv]
// checker: assertions on the stop control ports
`timescale 1ns/10ps
module seq_stop_ctrl_chk import seq_stop_pkg::*; (
  // clock and reset
  input  wire logic  crossbar_clock_i,
  input  wire logic  reset_n_i,
  // watched ports
  input  seq_ctrl_t   ctrl_i,
  input  seq_status_t status_o,
  input  wire logic  irq_o,
  input  wire logic  status_req_i,
  input  wire logic  status_ack_o,
  input  work_req_t   work_req_i,
  input  wire logic  work_ack_o,
  input  wire logic  burst_req_o,
  input  wire logic  sample_dma_req_i,
  input  wire logic  acq_active_i,
  input  wire logic  soft_reset_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge crossbar_clock_i); endclocking
  default disable iff (!reset_n_i);
  logic halted;
  assign halted = status_o.state inside {ST_STOP, ST_ASYNC_HALT};
  chk_halt_exit: assert property (halted && !status_o.fetch_active |=>
    status_o.state == ST_START && soft_reset_o) else $error("halt exit wrong");
  chk_reset_after_fetch: assert property (status_o.fetch_active |=> !soft_reset_o)
    else $error("soft reset while fetching");
  chk_reset_single: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset too long");
  chk_stop_req: assert property (status_o.state == ST_RUN && ctrl_i.stop_req
    && !ctrl_i.async_halt_req |=> status_o.state == ST_STOP) else $error("no stop state");
  chk_async_req: assert property (status_o.state == ST_RUN && ctrl_i.async_halt_req
    |=> status_o.state == ST_ASYNC_HALT) else $error("no async halt state");
  chk_irq_raise: assert property ($rose(status_o.stop_seen_flag) |-> irq_o)
    else $error("irq missing");
  chk_irq_cause: assert property (irq_o |-> $rose(status_o.stop_seen_flag))
    else $error("irq without flag");
  chk_flag_set: assert property (status_o.state == ST_STOP |=> status_o.stop_seen_flag)
    else $error("stop flag not set");
  chk_flag_clear: assert property (status_o.stop_seen_flag && ctrl_i.stop_seen_w1c
    && status_o.state != ST_STOP |=> !status_o.stop_seen_flag) else $error("w1c failed");
  chk_fetch_busy: assert property (burst_req_o |-> status_o.fetch_active)
    else $error("fetch active low");
  chk_preempt_gate: assert property (acq_active_i && sample_dma_req_i |-> !burst_req_o)
    else $error("burst during preempt");
  chk_status_ack: assert property (status_ack_o == status_req_i)
    else $error("status ack wrong");
  chk_work_ack: assert property ($rose(work_req_i.req) |-> ##[1:3] work_ack_o)
    else $error("work ack late");
  chk_ack_pulse: assert property (work_ack_o |=> !work_ack_o)
    else $error("work ack too long");
  cov_reset_hit: cover property (soft_reset_o && work_req_i.req);
  cov_irq: cover property (irq_o);
  cov_async: cover property (status_o.state == ST_ASYNC_HALT);
endmodule

bind seq_stop_ctrl seq_stop_ctrl_chk i_seq_stop_ctrl_chk (
  .crossbar_clock_i(crossbar_clock_i), .reset_n_i(reset_n_i), .ctrl_i(ctrl_i), .status_o(status_o),
  .irq_o(irq_o), .status_req_i(status_req_i), .status_ack_o(status_ack_o),
  .work_req_i(work_req_i), .work_ack_o(work_ack_o), .burst_req_o(burst_req_o),
  .sample_dma_req_i(sample_dma_req_i), .acq_active_i(acq_active_i),
  .soft_reset_o(soft_reset_o)
);

// [tb/system_crossbar_mem_model.sv]
// partner: crossbar memory answering instruction bursts
`timescale 1ns/10ps
module system_crossbar_mem_model (
  // clock and reset
  input  wire logic        crossbar_clock_i,
  input  wire logic        reset_n_i,
  // control from bench
  input  wire logic        stop_en_i,
  input  wire logic [3:0]  stop_slot_i,
  input  wire logic [3:0]  grant_delay_i,
  // crossbar side
  input  wire logic        burst_req_i,
  output logic             burst_grant_o,
  output logic             beat_valid_o,
  output logic [63:0]      beat_data_o,
  output logic [15:0]      beat_count_o
);
  // ****************************************
  // burst engine
  // ****************************************
  logic [4:0] left;
  logic [4:0] idx;
  logic [3:0] wait_cnt;
  logic [7:0] opc;
  assign opc = (stop_en_i && idx[4:1] == stop_slot_i) ? 8'h00 : 8'h11;
  always_ff @(posedge crossbar_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {burst_grant_o, beat_valid_o, left, idx, wait_cnt} <= '0;
      beat_data_o  <= '0;
      beat_count_o <= '0;
    end else begin
      if (left != 5'h00) begin
        // low half first, high half carries the opcode
        beat_valid_o <= 1'b1;
        left         <= left - 5'h01;
        idx          <= idx + 5'h01;
        beat_count_o <= beat_count_o + 16'h0001;
        beat_data_o  <= idx[0] ? {opc, 51'h0, idx[4:1], 1'b1} : {59'h0, idx};
      end else begin
        // idle bus must not look like a held beat
        beat_valid_o <= 1'b0;
        beat_data_o  <= ~beat_data_o;
      end
      if (burst_grant_o && burst_req_i) begin
        burst_grant_o <= 1'b0;
        left          <= 5'h10;
        wait_cnt      <= '0;
      end else if (burst_req_i && left == 5'h00 && !beat_valid_o && !burst_grant_o) begin
        if (wait_cnt >= grant_delay_i) burst_grant_o <= 1'b1;
        else wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// [tb/seq_stop_ctrl_test.sv]
// testbench: stop, restart and work-register access sequences
`timescale 1ns/10ps
module seq_stop_ctrl_test;
  import seq_stop_pkg::*;
  // ****************************************
  // signals and tasks
  // ****************************************
  logic        crossbar_clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  seq_ctrl_t   ctrl_i = '0;
  seq_status_t status_o;
  work_req_t   work_req_i = '0;
  logic        status_req_i = 1'b0;
  logic        sample_dma_req_i = 1'b0;
  logic        acq_active_i = 1'b0;
  logic        stop_en = 1'b0;
  logic [3:0]  grant_delay = 4'h0;
  logic        irq_o, status_ack_o, work_ack_o, burst_req_o, burst_grant_i, beat_valid_i;
  logic        soft_reset_o, instr_valid_o;
  logic [31:0] work_rdata_o, rd;
  logic [63:0] beat_data_i;
  logic [127:0] instr_o;
  logic [15:0] beats, beats0;
  int num_errors = 0, check_count = 0, cycles = 0, s0 = 0;
  int sr_cnt = 0, irq_cnt = 0, stop_cnt = 0, async_cnt = 0;
  int iv_cnt = 0, irq_wait = 0;

  seq_stop_ctrl i_seq_stop_ctrl (.crossbar_clock_i(crossbar_clock_i), .reset_n_i(reset_n_i),
    .ctrl_i(ctrl_i), .status_o(status_o), .irq_o(irq_o), .status_req_i(status_req_i),
    .status_ack_o(status_ack_o), .work_req_i(work_req_i), .work_ack_o(work_ack_o),
    .work_rdata_o(work_rdata_o), .burst_req_o(burst_req_o), .burst_grant_i(burst_grant_i),
    .beat_valid_i(beat_valid_i), .beat_data_i(beat_data_i),
    .sample_dma_req_i(sample_dma_req_i), .acq_active_i(acq_active_i),
    .soft_reset_o(soft_reset_o), .instr_valid_o(instr_valid_o), .instr_o(instr_o));
  system_crossbar_mem_model i_system_crossbar_mem_model (.crossbar_clock_i(crossbar_clock_i), .reset_n_i(reset_n_i),
    .stop_en_i(stop_en), .stop_slot_i(4'h0), .grant_delay_i(grant_delay),
    .burst_req_i(burst_req_o), .burst_grant_o(burst_grant_i), .beat_valid_o(beat_valid_i),
    .beat_data_o(beat_data_i), .beat_count_o(beats));

  task end_of_test;
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task tick;
    @(posedge crossbar_clock_i);
    #1;
  endtask
  task automatic pulse(input seq_ctrl_t c);
    ctrl_i = c;
    tick();
    ctrl_i = '0;
    tick();
  endtask
  task automatic work(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    work_req_i = {1'b1, wr, a, d};
    n = 0;
    while (work_ack_o !== 1'b1 && n < 8) begin
      tick();
      n++;
    end
    check("work ack", n < 8, 1'b1);
    rd = work_rdata_o;
    tick();
    work_req_i = '0;
    tick();
  endtask
  // polling cpu hammering work registers until the sequencer is back in start
  task automatic hammer;
    int n;
    n = 0;
    while (status_o.state !== ST_START && n < 200) begin
      work(1'b0, 8'h08, 32'h0);
      n++;
    end
    // one more edge so the counters below have seen the soft-reset pulse
    tick();
  endtask

  always #2 crossbar_clock_i = ~crossbar_clock_i;
  always @(posedge crossbar_clock_i) begin
    cycles++;
    status_req_i <= #1 ~status_req_i;
    sample_dma_req_i <= #1 cycles[1];
    if (soft_reset_o === 1'b1) sr_cnt++;
    if (irq_o === 1'b1) irq_cnt++;
    if (instr_valid_o === 1'b1) iv_cnt++;
    if (status_o.state === ST_STOP) stop_cnt++;
    if (status_o.state === ST_ASYNC_HALT) async_cnt++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge crossbar_clock_i);
    #1 reset_n_i = 1'b1;
    check("status rst", status_o, 32'h0000_0000);
    tick();
    work(1'b1, 8'h04, 32'h1234_5678);
    work(1'b0, 8'h04, 32'h0000_0000);
    check("work rd", rd, 32'h1234_5678);
    // stop opcode first in its group: fifteen more still fetched
    stop_en = 1'b1;
    beats0 = beats;
    pulse(5'h10);
    hammer();
    check("state", status_o.state, ST_START);
    check("stop seen", status_o.stop_seen_flag, 1'b1);
    check("irq count", irq_cnt, 1);
    check("soft rst", sr_cnt, 1);
    check("beats", beats - beats0, 16'h0020);
    check("instr count", iv_cnt, 16);
    check("last instr", {instr_o[127:120], instr_o[71:64], instr_o[7:0]}, 32'h0011_1f1e);
    pulse(5'h02);
    check("stop w1c", status_o.stop_seen_flag, 1'b0);
    check("fetch idle", status_o.fetch_active, 1'b0);
    work(1'b0, 8'h04, 32'h0000_0000);
    check("work cleared", rd, 32'h0000_0000);
    // software stop while a slow group is in flight
    stop_en = 1'b0;
    grant_delay = 4'h3;
    beats0 = beats;
    s0 = stop_cnt;
    pulse(5'h10);
    repeat (6) tick();
    pulse(5'h08);
    // software reacts on the interrupt rather than polling the flag
    while (irq_o !== 1'b1 && irq_wait < 200) begin
      tick();
      irq_wait++;
    end
    check("irq seen", irq_wait < 200, 1'b1);
    hammer();
    check("via stop", stop_cnt > s0, 1'b1);
    check("flags", {status_o.stop_seen_flag, status_o.async_halt_seen_flag}, 2'b10);
    check("whole groups", (beats - beats0) % 16'h0020, 16'h0000);
    check("soft rst 2", sr_cnt, 2);
    pulse(5'h02);
    // async halt during acquisition, sample dma pre-empting
    acq_active_i = 1'b1;
    pulse(5'h10);
    repeat (4) tick();
    pulse(5'h04);
    hammer();
    check("via async", async_cnt > 0, 1'b1);
    check("flags 2", {status_o.stop_seen_flag, status_o.async_halt_seen_flag}, 2'b01);
    check("soft rst 3", sr_cnt, 3);
    check("irq count 2", irq_cnt, 2);
    pulse(5'h01);
    check("async w1c", status_o.async_halt_seen_flag, 1'b0);
    end_of_test();
  end
endmodule
